// File: bench/test_temp_sensor_autoconvert_readout.sv
// self-checking bench for the temperature readout block
// assumes short conversion counts and the behavioural serial master
`timescale 1ns/1ps
module test_temp_sensor_autoconvert_readout;
  localparam int UPD = 400, CNV = 25;
  localparam logic [9:0] CODES [4] = '{10'h200, 10'h1FF, 10'h3FF, 10'h001};
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, select_i, serial_clk_i, serial_in_i;
  logic serial_out_o, serial_out_oe_n_o, converting_o, shutdown_o;
  logic [9:0] adc_code_i = 10'h000, temperature_result_o, model;
  logic [15:0] rx;
  logic [7:0] lfsr = 8'h1C;
  int num_errors = 0, comparisons = 0;
  always #2 core_clk_i = ~core_clk_i;
  tsr_readout #(.UPDATE_CYC(UPD), .CONV_CYC(CNV)) u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .select_i(select_i), .serial_clk_i(serial_clk_i), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
    .serial_out_oe_n_o(serial_out_oe_n_o), .adc_code_i(adc_code_i), .converting_o(converting_o),
    .shutdown_o(shutdown_o), .temperature_result_o(temperature_result_o));
  tsr_master u_mst (.select_o(select_i), .sclk_o(serial_clk_i), .serial_in_o(serial_in_i),
    .serial_out_i(serial_out_o));
  task automatic check(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h got %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // code changes only while no conversion runs (idle or shutdown), so no sample can tear
  task automatic set_code(input logic [9:0] c);
    for (int k = 0; k < 100 && converting_o !== 1'b0; k++) cyc(1);
    if (converting_o !== 1'b0) begin
      num_errors++;
      stop_test();
    end
    adc_code_i = c;
  endtask
  // full frame: leading zero, ten bits msb first, then zeros
  task automatic rd(input logic pd);
    u_mst.frame(pd, 16, rx);
    check("frame", {1'b0, model, 5'h00}, rx);
    check("result", {6'h00, model}, {6'h00, temperature_result_o});
  endtask
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  initial begin
    cyc(5);
    rst_n_i = 1'b1;
    cyc(10);
    for (int i = 0; i < 6; i++) begin
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      set_code(i < 4 ? CODES[i] : {lfsr, lfsr[1:0]});
      cyc(UPD + CNV);
      model = adc_code_i;
      rd(1'b0);
    end
    rd(1'b1);
    check("enter", 16'h0001, {15'h0000, shutdown_o});
    set_code(10'h155);
    cyc(UPD + CNV);
    rd(1'b1);
    u_mst.frame(1'b0, 14, rx);
    check("abort", 16'h0001, {15'h0000, shutdown_o});
    u_mst.frame(1'b0, 16, rx);
    check("frame", {1'b0, model, 5'h00}, rx);
    model = 10'h155;
    check("result", {6'h00, model}, {6'h00, temperature_result_o});
    check("leave", 16'h0000, {15'h0000, shutdown_o});
    cyc(CNV + 10);
    check("wake", {6'h00, model}, {6'h00, temperature_result_o});
    set_code(10'h0A5);
    rd(1'b0);
    cyc(CNV + 10);
    check("restart", 16'h00A5, {6'h00, temperature_result_o});
    stop_test();
  end
endmodule

// File: bench/tsr_master.sv
// serial master model for the sensor port
// assumes a 64 ns serial clock that stands still between frames
`timescale 1ns/1ps
module tsr_master (
  output logic select_o, sclk_o, serial_in_o,
  input  wire  serial_out_i
);
  initial {select_o, sclk_o, serial_in_o} = 3'h0;
  // one frame of n clocks; only the power-down bit may be set
  task automatic frame(input logic pd, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    select_o = 1'b1;
    #32;
    for (int i = 0; i < n; i++) begin
      serial_in_o = (i == 2) ? pd : 1'b0;
      sclk_o = 1'b1;
      #32;
      rx = {rx[14:0], serial_out_i}; // late in high phase
      sclk_o = 1'b0;
      #32;
    end
    select_o = 1'b0;
    #64;
  endtask
endmodule

// File: bench/tsr_properties.sv
// port checker for the temperature readout block
// assumes short conversion counts handed in by the bind
`timescale 1ns/1ps
module tsr_props #(parameter int UPDATE_CYC = 400, parameter int CONV_CYC = 25) (
  input wire       core_clk_i, rst_n_i, select_i, serial_clk_i, serial_in_i,
  input wire       serial_out_o, serial_out_oe_n_o, converting_o, shutdown_o,
  input wire [9:0] adc_code_i, temperature_result_o
);
  int conv_q, idle_q;
  // run lengths of busy and idle phases
  always @(posedge core_clk_i) begin
    conv_q <= (rst_n_i && converting_o) ? conv_q + 1 : 0;
    idle_q <= (rst_n_i && !converting_o && !shutdown_o) ? idle_q + 1 : 0;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  oe_off_a: assert property ($fell(select_i) |-> ##[1:6] serial_out_oe_n_o) else $error("pin kept");
  oe_on_a: assert property (select_i [*6] |-> !serial_out_oe_n_o) else $error("pin not driven");
  out_hold_a: assert property (!serial_clk_i [*7] |-> $stable(serial_out_o)) else $error("data moved");
  conv_len_a: assert property ($fell(converting_o) |-> conv_q == CONV_CYC) else $error("bad length");
  idle_len_a: assert property (idle_q <= UPDATE_CYC - CONV_CYC) else $error("start late");
  sd_hold_a: assert property (shutdown_o |-> !$rose(converting_o)) else $error("ran in shutdown");
  res_src_a: assert property ($changed(temperature_result_o) |-> $past(converting_o))
    else $error("result moved while idle");
  res_val_a: assert property ($changed(temperature_result_o) |-> temperature_result_o == $past(adc_code_i))
    else $error("torn result");
  cover property ($fell(converting_o));
  cover property ($rose(shutdown_o));
  cover property ($fell(shutdown_o));
endmodule
bind tsr_readout tsr_props #(.UPDATE_CYC(UPDATE_CYC), .CONV_CYC(CONV_CYC)) u_props (.core_clk_i, .rst_n_i,
  .select_i, .serial_clk_i, .serial_in_i, .serial_out_o, .serial_out_oe_n_o, .converting_o, .shutdown_o,
  .adc_code_i, .temperature_result_o);

// File: rtl/tsr_consts.vh
// constants for the temperature sensor readout block
// assumes inclusion by plain name from rtl files
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH
`define TSR_CLK_MHZ          250
`define TSR_UPDATE_US        400
`define TSR_CONV_US          25
`define TSR_UPDATE_CYC       (`TSR_UPDATE_US * `TSR_CLK_MHZ)
`define TSR_CONV_CYC         (`TSR_CONV_US * `TSR_CLK_MHZ)
`define TSR_RES_W            10
`define TSR_RES_RST          10'h000
`define TSR_FRAME_BITS       16
`define TSR_LOAD_EDGE        15
`define TSR_PD_BIT_POS       3
`endif

// File: rtl/tsr_readout.v
// digital side of an auto-converting temperature sensor with serial port
// assumes serial pins are asynchronous; converter modelled as sample of adc_code_i
// Overview of operation
// (R01) port responds only while select is high; clock ignored when low
// (R02) one serial clock shifts result out and control bits in together
// (R03) result register presented bit by bit on serial_out
// (R04) master supplies control bits on serial_in
// (R05) sequencer starts a conversion every 400 us in normal mode
// (R06) conversion lasts 25 us, then converter returns to idle
// (R07) result register holds latest completed conversion
// (R08) shutdown stops oscillator; no new conversions start
// (R09) result kept and readable during shutdown
// (R10) completing a serial access restarts oscillator; result 25 us later
// (R11) leaving shutdown restarts oscillator and launches a conversion
// (R12) read before pending conversion ends returns previous value
// (R13) result is read-only 10-bit two's complement, top bit sign
// (R14) one step is 0.25 C, codes span -128 to +127 C
// (R15) read frame is 16 clocks: leading zero then 10 bits msb first
// (R16) input sampled on falling edge, output changed on rising edge
// (R17) third bit is power-down, loaded on 15th rising edge
// (R18) select falling before 15th rising edge discards control bits
// (R19) result updated atomically at conversion end
`timescale 1ns/1ps
`include "tsr_consts.vh"
module tsr_readout #(
  parameter UPDATE_CYC = `TSR_UPDATE_CYC,
  parameter CONV_CYC   = `TSR_CONV_CYC
) (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  // serial port pins
  input  wire        select_i,
  input  wire        serial_clk_i,
  input  wire        serial_in_i,
  output reg         serial_out_o,
  output reg         serial_out_oe_n_o,
  // analog converter output code
  input  wire [9:0]  adc_code_i,
  // status
  output reg         converting_o,
  output reg         shutdown_o,
  output reg  [9:0]  temperature_result_o
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_SHDN = 3'b100;

  wire [2:0] pins_s;
  reg        sclk_q;
  reg        sel_q;
  reg  [2:0] state_q;
  reg  [20:0] tick_q;
  reg  [4:0] redge_q;
  reg  [15:0] shift_in_q;
  reg  [10:0] shift_out_q;
  reg  [9:0] result_q;
  reg        restart_q;

  // pins are outside our domain
  tsr_sync #(.W(3)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({select_i, serial_clk_i, serial_in_i}),
    .sync_o     (pins_s)
  );

  wire sel_s  = pins_s[2];
  wire sclk_s = pins_s[1];
  wire serial_in_s = pins_s[0];
  wire rise   = sel_s & sclk_s & ~sclk_q;   // (R01)
  wire fall   = sel_s & ~sclk_s & sclk_q;   // (R01)
  wire desel  = sel_q & ~sel_s;
  wire load15 = rise & (redge_q == 5'd14);  // (R18) only a full 15th rising edge loads

  // edge history
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      sel_q  <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      sel_q  <= sel_s;
    end
  end

  // serial shifters; result snapshot taken at select rise so frame stays coherent
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      redge_q           <= 5'd0;
      shift_in_q        <= 16'h0000;
      shift_out_q       <= 11'h000;
      serial_out_o      <= 1'b0;
      serial_out_oe_n_o <= 1'b1;
    end else if (!sel_s) begin
      redge_q           <= 5'd0;
      serial_out_oe_n_o <= 1'b1;              // released while deselected
      shift_out_q       <= {1'b0, result_q};  // (R15)
    end else begin
      serial_out_oe_n_o <= 1'b0;
      if (rise) begin
        // (R16) output moves on rising edge
        if (redge_q != 5'd31)
          redge_q <= redge_q + 5'd1;
        serial_out_o <= shift_out_q[10];      // (R03) (R15)
        shift_out_q  <= {shift_out_q[9:0], 1'b0}; // (R02)
      end
      if (fall)
        shift_in_q <= {shift_in_q[14:0], serial_in_s}; // (R16) (R02)
    end
  end

  // sequencer, shutdown and conversion
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q   <= ST_CONV;
      tick_q    <= 21'd0;
      result_q  <= `TSR_RES_RST;
      restart_q <= 1'b0;
    end else begin
      // access completion restarts oscillator
      if (desel)
        restart_q <= 1'b1;                  // (R10)
      // control load; fourteen falls seen, so the third received bit sits at 14-3
      if (load15 && shift_in_q[`TSR_LOAD_EDGE-1-`TSR_PD_BIT_POS]) begin
        state_q   <= ST_SHDN;               // (R17) (R08)
        restart_q <= 1'b0;
      end else if (load15 && state_q == ST_SHDN) begin
        state_q   <= ST_CONV;               // (R11)
        tick_q    <= 21'd0;
        restart_q <= 1'b0;
      end else begin
        case (state_q)
          ST_CONV: begin
            if (tick_q >= CONV_CYC - 1) begin
              result_q <= adc_code_i;       // (R07) (R19) (R13) (R14)
              state_q  <= ST_IDLE;          // (R06)
              tick_q   <= 21'd0;
            end else
              tick_q <= tick_q + 21'd1;     // (R12)
          end
          ST_IDLE: begin
            if (restart_q && !sel_s) begin
              restart_q <= 1'b0;
              state_q   <= ST_CONV;         // (R10)
              tick_q    <= 21'd0;
            end else if (tick_q >= UPDATE_CYC - CONV_CYC - 1) begin
              state_q <= ST_CONV;           // (R05)
              tick_q  <= 21'd0;
            end else
              tick_q <= tick_q + 21'd1;
          end
          ST_SHDN: begin
            tick_q    <= 21'd0;             // (R08) (R09)
            restart_q <= 1'b0;
          end
          default: state_q <= ST_CONV;
        endcase
      end
    end
  end

  // registered status outputs
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      converting_o         <= 1'b0;
      shutdown_o           <= 1'b0;
      temperature_result_o <= `TSR_RES_RST;
    end else begin
      converting_o         <= (state_q == ST_CONV);
      shutdown_o           <= (state_q == ST_SHDN);
      temperature_result_o <= result_q;
    end
  end
endmodule

// File: rtl/tsr_sync.v
// two flip-flop synchroniser, one per bit
// assumes inputs asynchronous to core_clk_i
`timescale 1ns/1ps
module tsr_sync #(
  parameter W = 3
) (
  input  wire         core_clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  genvar g;
  // first stage read only by second stage
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= async_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate
  assign sync_o = sync_q;
endmodule
